// file: rtl/port_b_pin_data_io.sv
// Purpose: eight-bit general-purpose port with change and edge interrupts
// Assumes: register port with one-cycle read latency, inputs synchronous
// Notes:   flags set by hardware win over software clears
// Notes on behaviour
// - direction bit one tristates the pin driver
// - direction bit zero drives the output latch value
// - all pull-ups enabled by clearing option bit seven
// - pull-up off for any pin acting as output
// - option resets to all ones, pull-ups off
// - pins seven to four compared only when inputs
// - compare inputs against value latched at last data read or write
// - mismatches ORed set change flag bit zero of interrupt control
// - change interrupt wakes device from sleep
// - any data read or write refreshes compare latch
// - persisting mismatch keeps setting flag over clears
// - pin zero external interrupt, edge from option bit six
// - enabled peripheral overrides pin direction
// - direction resets to all ones on every reset
// - low-voltage programming default disables pin three output drive
// - data read returns pins, write updates output latch and compare latch
//
// Local design decision: the strobed register port.
`default_nettype none
`include "port_b_pin_data_defines.svh"
module port_b_pin_data_io
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [8:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata,
  input  wire logic [7:0] pin_in,
  output var  logic [7:0] pin_out,
  output var  logic [7:0] pin_oe,
  output var  logic [7:0] pin_pullup,
  input  wire logic [7:0] periph_en,
  input  wire logic [7:0] periph_dir,
  input  wire logic [7:0] periph_out,
  input  wire logic       lvp_disable,
  input  wire logic       sleeping,
  output var  logic       wake,
  output var  logic       change_int_flag,
  output var  logic       ext_int_flag
);
  port_b_pin_data_pkg::byte_t latch_r, latch_nxt;
  port_b_pin_data_pkg::byte_t dir_r, dir_nxt;
  port_b_pin_data_pkg::byte_t opt_r, opt_nxt;
  port_b_pin_data_pkg::byte_t old_r, old_nxt;
  port_b_pin_data_pkg::byte_t rdata_nxt;
  port_b_pin_data_pkg::change_e state_r, state_nxt;
  logic             chg_r, chg_nxt;
  logic             ext_r, ext_nxt;
  logic             pin0_r, pin0_nxt;
  logic             wake_nxt;
  logic             lvp_r, lvp_nxt;
  logic [1:0]       settle_r, settle_nxt;
  logic [7:0]       pins;
  logic [3:0]       mism;
  logic             any_mism;
  logic             hit_data;
  logic             hit_opt;
  logic             hit_dir;
  logic             hit_int;
  logic             edge_hit;

  pin_sync u_sync
  (
    .clock        (clock),
    .rst_n        (rst_n),
    .pin_in       (pin_in),
    .pin_sync_out (pins)
  );

  pin_drive u_drive
  (
    .clock                 (clock),
    .rst_n                 (rst_n),
    .latch                 (latch_r),
    .direction             (dir_r),
    .periph_en             (periph_en),
    .periph_dir            (periph_dir),
    .periph_out            (periph_out),
    .pullup_disable_n      (opt_r[`BIT_PULLUP_DIS_N]),
    .low_voltage_prog_mode (lvp_r),
    .pin_out               (pin_out),
    .pin_oe                (pin_oe),
    .pin_pullup            (pin_pullup)
  );

  assign hit_data = (addr == `ADDR_PORT_DATA);
  assign hit_opt  = (addr == `ADDR_OPTION);
  assign hit_dir  = (addr == `ADDR_DIRECTION);
  assign hit_int  = (addr == `ADDR_INT_CONTROL);

  genvar g;
  generate
    for (g = `CHANGE_LO; g <= `CHANGE_HI; g++)
    begin : g_cmp
      logic eff_in;
      assign eff_in = periph_en[g] ? periph_dir[g] : dir_r[g];
      assign mism[g - `CHANGE_LO] = eff_in && (pins[g] != old_r[g]);
    end
  endgenerate

  assign any_mism = |mism;

  // edges are ignored until the synchroniser and the previous-level flop
  // hold real pin levels, so a pin that is high out of reset is no edge
  assign edge_hit = (settle_r == `SYNC_SETTLE) &&
                    (opt_r[`BIT_EXT_EDGE_SEL] ? (pins[0] && !pin0_r)
                                              : (!pins[0] && pin0_r));

  // software-visible registers and the change compare latch
  always_comb
  begin
    latch_nxt = latch_r;
    dir_nxt   = dir_r;
    opt_nxt   = opt_r;
    old_nxt   = old_r;
    if (wr && hit_data)
    begin
      latch_nxt = wdata;
    end
    if (wr && hit_opt)
    begin
      opt_nxt = wdata;
    end
    if (wr && hit_dir)
    begin
      dir_nxt = wdata;
    end
    if ((wr || rd) && hit_data)
    begin
      old_nxt = pins;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_r <= `RESET_BYTE_ZERO;
      dir_r   <= `RESET_DIRECTION;
      opt_r   <= `RESET_OPTION;
      old_r   <= `RESET_BYTE_ZERO;
    end
    else
    begin
      latch_r <= latch_nxt;
      dir_r   <= dir_nxt;
      opt_r   <= opt_nxt;
      old_r   <= old_nxt;
    end
  end

  // interrupt flags: a hardware set in the same cycle beats a software clear
  always_comb
  begin
    chg_nxt    = chg_r;
    ext_nxt    = ext_r;
    pin0_nxt   = pins[0];
    settle_nxt = settle_r;
    if (settle_r != `SYNC_SETTLE)
    begin
      settle_nxt = settle_r + 2'h1;
    end
    if (wr && hit_int)
    begin
      chg_nxt = wdata[`BIT_CHANGE_FLAG];
      ext_nxt = wdata[`BIT_EXT_FLAG];
    end
    if (any_mism)
    begin
      chg_nxt = 1'b1;
    end
    if (edge_hit)
    begin
      ext_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chg_r           <= 1'b0;
      ext_r           <= 1'b0;
      pin0_r          <= 1'b0;
      settle_r        <= `RESET_SETTLE;
      change_int_flag <= 1'b0;
      ext_int_flag    <= 1'b0;
    end
    else
    begin
      chg_r           <= chg_nxt;
      ext_r           <= ext_nxt;
      pin0_r          <= pin0_nxt;
      settle_r        <= settle_nxt;
      change_int_flag <= chg_nxt;
      ext_int_flag    <= ext_nxt;
    end
  end

  // low-voltage programming mode clears once and stays clear until reset
  always_comb
  begin
    lvp_nxt = lvp_r && !lvp_disable;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvp_r <= 1'b1;
    end
    else
    begin
      lvp_r <= lvp_nxt;
    end
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always_comb
  begin
    rdata_nxt = `RESET_BYTE_ZERO;
    if (rd)
    begin
      if (hit_data)
      begin
        rdata_nxt = pins;
      end
      else if (hit_opt)
      begin
        rdata_nxt = opt_r;
      end
      else if (hit_dir)
      begin
        rdata_nxt = dir_r;
      end
      else if (hit_int)
      begin
        rdata_nxt[`BIT_CHANGE_FLAG] = chg_r;
        rdata_nxt[`BIT_EXT_FLAG]    = ext_r;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= `RESET_BYTE_ZERO;
    end
    else
    begin
      rdata <= rdata_nxt;
    end
  end

  // wake follows sleep once a pin mismatch is seen while sleeping: it is registered and drops in the cycle after sleeping falls
  always_comb
  begin
    state_nxt = state_r;
    wake_nxt  = 1'b0;
    case (state_r)
      port_b_pin_data_pkg::ST_IDLE:
        if (any_mism)
        begin
          state_nxt = port_b_pin_data_pkg::ST_MISM;
        end
      port_b_pin_data_pkg::ST_MISM:
        if (sleeping)
        begin
          state_nxt = port_b_pin_data_pkg::ST_AWAKE;
        end
        else if (!any_mism)
        begin
          state_nxt = port_b_pin_data_pkg::ST_IDLE;
        end
      port_b_pin_data_pkg::ST_AWAKE:
      begin
        wake_nxt = sleeping;
        if (!sleeping)
        begin
          state_nxt = any_mism ? port_b_pin_data_pkg::ST_MISM : port_b_pin_data_pkg::ST_IDLE;
        end
      end
      default:
        state_nxt = port_b_pin_data_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= port_b_pin_data_pkg::ST_IDLE;
      wake    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      wake    <= wake_nxt;
    end
  end
endmodule // port_b_pin_data_io
`default_nettype wire

// file: rtl/port_b_pin_data_defines.svh
// Purpose: constants for the second general-purpose port
// Assumes: register indices are nine-bit core addresses
// Notes:   included by the port, synchroniser and driver modules
`ifndef PORT_B_PIN_DATA_DEFINES_SVH
`define PORT_B_PIN_DATA_DEFINES_SVH
`define ADDR_PORT_DATA      9'h006
`define ADDR_OPTION         9'h081
`define ADDR_DIRECTION      9'h086
`define ADDR_INT_CONTROL    9'h00B
`define RESET_OPTION        8'hFF
`define RESET_DIRECTION     8'hFF
`define RESET_BYTE_ZERO     8'h00
`define BIT_PULLUP_DIS_N    7
`define BIT_EXT_EDGE_SEL    6
`define BIT_CHANGE_FLAG     0
`define BIT_EXT_FLAG        1
`define BIT_PROG_PIN        3
`define CHANGE_LO           4
`define CHANGE_HI           7
`define SYNC_SETTLE         2'h3
`define RESET_SETTLE        2'h0
`endif

// file: rtl/port_b_pin_data_pkg.sv
// Purpose: types for the second general-purpose port
// Assumes: nothing beyond the defines header
// Notes:   only types live here
`default_nettype none
package port_b_pin_data_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_MISM  = 2'b01,
    ST_AWAKE = 2'b11
  } change_e;
endpackage
`default_nettype wire

// file: rtl/pin_sync.sv
// Purpose: two-flop synchroniser per pin
// Assumes: single clock
// Notes:   first stage is read only by the second
`default_nettype none
`include "port_b_pin_data_defines.svh"
module pin_sync
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] pin_in,
  output var  logic [7:0] pin_sync_out
);
  logic [7:0] meta_r;
  logic [7:0] meta_nxt;
  logic [7:0] sync_nxt;

  always_comb
  begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r       <= `RESET_BYTE_ZERO;
      pin_sync_out <= `RESET_BYTE_ZERO;
    end
    else
    begin
      meta_r       <= meta_nxt;
      pin_sync_out <= sync_nxt;
    end
  end
endmodule // pin_sync
`default_nettype wire

// file: rtl/pin_drive.sv
// Purpose: per-pin driver, enable and pull-up control
// Assumes: overrides come from sharing peripherals
// Notes:   registered outputs
`default_nettype none
`include "port_b_pin_data_defines.svh"
module pin_drive
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] latch,
  input  wire logic [7:0] direction,
  input  wire logic [7:0] periph_en,
  input  wire logic [7:0] periph_dir,
  input  wire logic [7:0] periph_out,
  input  wire logic       pullup_disable_n,
  input  wire logic       low_voltage_prog_mode,
  output var  logic [7:0] pin_out,
  output var  logic [7:0] pin_oe,
  output var  logic [7:0] pin_pullup
);
  logic [7:0] out_nxt;
  logic [7:0] oe_nxt;
  logic [7:0] pu_nxt;
  logic [7:0] eff_dir;
  logic [7:0] blocked;

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_pin
      assign eff_dir[g] = periph_en[g] ? periph_dir[g] : direction[g];
      assign blocked[g] = (g == `BIT_PROG_PIN) && low_voltage_prog_mode;
    end
  endgenerate

  always_comb
  begin
    out_nxt = (periph_en & periph_out) | (~periph_en & latch);
    oe_nxt  = ~eff_dir & ~blocked;
    pu_nxt  = {8{!pullup_disable_n}} & eff_dir;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out    <= `RESET_BYTE_ZERO;
      pin_oe     <= `RESET_BYTE_ZERO;
      pin_pullup <= `RESET_BYTE_ZERO;
    end
    else
    begin
      pin_out    <= out_nxt;
      pin_oe     <= oe_nxt;
      pin_pullup <= pu_nxt;
    end
  end
endmodule // pin_drive
`default_nettype wire

// file: testbench/port_b_pin_data_io_chk.sv
// Purpose: port-side assertions for port_b_pin_data_io
// Assumes: lvp_disable stays high once raised
// Notes:   bound into every port_b_pin_data_io instance
`default_nettype none
module port_b_pin_data_io_chk
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] periph_en,
  input wire logic       lvp_disable,
  input wire logic       sleeping,
  input wire logic       wake,
  input wire logic       change_int_flag,
  input wire logic       ext_int_flag
);
  timeunit 1ns; timeprecision 1ps;
  logic lvp_seen_r;
  logic lvp_seen_nxt;
  always_comb lvp_seen_nxt = lvp_seen_r | lvp_disable;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) lvp_seen_r <= 1'b0;
    else lvp_seen_r <= lvp_seen_nxt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_OE_WR:
    assert property (wr && addr == 9'h086 && lvp_disable && periph_en == 8'h00 ##1
      !wr && periph_en == 8'h00 |=> pin_oe == ~$past(wdata, 2)) else $error("oe vs dir");
  AST_PULL_OUT:
    assert property ((pin_pullup & pin_oe) == 8'h00) else $error("pullup on output");
  AST_PULL_RST:
    assert property ($rose(rst_n) |-> ##2 pin_pullup == 8'h00) else $error("pullup at reset");
  AST_PIN3:
    assert property (!lvp_seen_r && !lvp_disable |-> !pin_oe[3]) else $error("pin3 driven");
  AST_RDATA_IDLE:
    assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  AST_UNMAPPED:
    assert property (rd && !(addr inside {9'h006, 9'h081, 9'h086, 9'h00B}) |=>
      rdata == 8'h00) else $error("unmapped read");
  AST_WAKE_DROP:
    assert property (!sleeping |=> !wake) else $error("wake while awake");
  AST_CHG_HOLD:
    assert property ($fell(change_int_flag) |-> $past(wr && addr == 9'h00B))
    else $error("change flag lost");
  AST_EXT_HOLD:
    assert property ($fell(ext_int_flag) |-> $past(wr && addr == 9'h00B))
    else $error("ext flag lost");
endmodule // port_b_pin_data_io_chk
bind port_b_pin_data_io port_b_pin_data_io_chk u_chk (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .pin_oe,
  .pin_pullup, .periph_en, .lvp_disable, .sleeping, .wake, .change_int_flag, .ext_int_flag);
`default_nettype wire

// file: testbench/port_b_pin_data_pins.sv
// Purpose: external pin model resolving drive, pull-up and outside level
// Assumes: outside drivers only where ext_en is set
// Notes:   an undriven pin without pull-up toggles every cycle
`default_nettype none
module port_b_pin_data_pins
(
  input  wire logic       clock,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output wire logic [7:0] pin_in
);
  timeunit 1ns; timeprecision 1ps;
  logic flip = 1'b0;
  always @(posedge clock) flip <= ~flip;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | {8{flip}}));
endmodule // port_b_pin_data_pins
`default_nettype wire

// file: testbench/port_b_io_with_change_irq_tb.sv
// Purpose: self-checking bench for port_b_pin_data_io
// Assumes: register port with one-cycle read data
// Notes:   random direction, latch and pin levels from a fixed seed
`default_nettype none
module port_b_io_with_change_irq_tb;
  timeunit 1ns; timeprecision 1ps;
  logic clock = 0, rst_n = 0, wr = 0, rd = 0, lvp_disable = 0, sleeping = 0;
  logic [8:0] addr = 0;
  logic [7:0] wdata = 0, rdata, pin_in, pin_out, pin_oe, pin_pullup, v, d, l, x;
  logic [7:0] periph_en = 0, periph_dir = 0, periph_out = 0, ext_en = 8'hFF, ext_val = 0;
  logic wake, change_int_flag, ext_int_flag;
  int n_mismatch = 0, compares = 0;
  port_b_pin_data_io uut (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .pin_in, .pin_out, .pin_oe,
    .pin_pullup, .periph_en, .periph_dir, .periph_out, .lvp_disable, .sleeping, .wake,
    .change_int_flag, .ext_int_flag);
  port_b_pin_data_pins u_pins (.clock, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_in);
  initial forever #5 clock = ~clock;
  task automatic tick(input int n); repeat (n) @(posedge clock); endtask
  task automatic wreg(input logic [8:0] a, input logic [7:0] dv);
    addr <= a; wdata <= dv; wr <= 1; @(posedge clock); wr <= 0; @(posedge clock);
  endtask
  task automatic rreg(input logic [8:0] a, output logic [7:0] rv);
    addr <= a; rd <= 1; @(posedge clock); rd <= 0; #1 rv = rdata; @(posedge clock);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] pins(input logic [7:0] lt, dr, ex);
    return (lt & ~dr) | (ex & dr);
  endfunction
  task automatic give_verdict;
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000 n_mismatch++;
    give_verdict;
  end
  initial
  begin
    void'($urandom(72));
    tick(6); rst_n <= 1; tick(1);
    chk(pin_pullup, 8'h00);
    rreg(9'h081, v); chk(v, 8'hFF);
    rreg(9'h086, v); chk(v, 8'hFF);
    wreg(9'h086, 8'h00); tick(2); chk(pin_oe, 8'hF7);
    lvp_disable <= 1; wreg(9'h081, 8'h7F);
    for (int i = 0; i < 20; i++)
    begin
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      l = 8'($urandom); x = 8'($urandom); ext_val <= x;
      wreg(9'h006, l); wreg(9'h086, d); tick(4);
      chk(pin_oe, ~d);
      chk(pin_out & ~d, l & ~d);
      chk(pin_pullup, d);
      rreg(9'h006, v); chk(v, pins(l, d, x));
    end
    wreg(9'h081, 8'hFF); tick(2); chk(pin_pullup, 8'h00);
    rreg(9'h0FF, v); chk(v, 8'h00);
    periph_en <= 8'h03; periph_dir <= 8'h02; periph_out <= 8'h01;
    wreg(9'h086, 8'hF0); tick(2);
    chk(pin_oe, 8'h0D);
    chk(pin_out & 8'h0D, {4'h0, l[3:2], 2'b01});
    periph_en <= 8'h00; ext_val <= 8'h00; tick(4);
    rreg(9'h006, v); wreg(9'h00B, 8'h00); chk(7'h0 | change_int_flag, 8'h00);
    ext_val <= 8'h20; tick(5); chk(7'h0 | change_int_flag, 8'h01);
    wreg(9'h00B, 8'h00); chk(7'h0 | change_int_flag, 8'h01);
    wreg(9'h006, 8'h00); wreg(9'h00B, 8'h00); chk(7'h0 | change_int_flag, 8'h00);
    sleeping <= 1; ext_val <= 8'h60; tick(7); chk(7'h0 | wake, 8'h01);
    sleeping <= 0; tick(2); chk(7'h0 | wake, 8'h00);
    wreg(9'h086, 8'hF1);
    for (int e = 0; e < 2; e++)
    begin
      wreg(9'h081, {2'b11 & {1'b1, e[0]}, 6'h3F}); ext_val <= {7'h30, ~e[0]}; tick(4);
      wreg(9'h00B, 8'h00); chk(7'h0 | ext_int_flag, 8'h00);
      ext_val <= {7'h30, e[0]}; tick(5); chk(7'h0 | ext_int_flag, 8'h01);
    end
    give_verdict;
  end
endmodule // port_b_io_with_change_irq_tb
`default_nettype wire
